// file: port3_pkg.sv
// constants for the eight-line port with external-bus control functions
package port3_pkg;

    // ------------------------------------------------------------
    // register map: index is the printed offset, byte address = 4x
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 12;
    localparam logic [7:0]  IDX_DATA         = 8'h18;
    localparam logic [7:0]  IDX_DIRECTION    = 8'h1a;
    localparam logic [7:0]  IDX_FUNCTION     = 8'h1b;
    localparam logic [11:0] ADDR_DATA        = {2'h0, IDX_DATA, 2'h0};
    localparam logic [11:0] ADDR_DIRECTION   = {2'h0, IDX_DIRECTION, 2'h0};
    localparam logic [11:0] ADDR_FUNCTION    = {2'h0, IDX_FUNCTION, 2'h0};

    // ------------------------------------------------------------
    // reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0]  LATCH_RESET      = 8'hff;
    localparam logic [7:0]  STRAP_MASK       = 8'h7c;
    localparam logic [7:0]  DIR_RESET        = 8'h00;
    localparam logic [7:0]  FUNC_RESET       = 8'h00;
    localparam logic [7:0]  DIR_IMPL_MASK    = 8'hfc;
    localparam logic [7:0]  FUNC_IMPL_MASK   = 8'h77;
    localparam logic [7:0]  OUT_ONLY_MASK    = 8'h03;

    // ------------------------------------------------------------
    // line positions of the bus functions
    // ------------------------------------------------------------
    localparam int          LINE_RD          = 0;
    localparam int          LINE_WR          = 1;
    localparam int          LINE_HWR         = 2;
    localparam int          LINE_BUS_REQUEST_IN       = 4;
    localparam int          LINE_BUS_ACKNOWLEDGE_OUT       = 5;
    localparam int          LINE_RW          = 6;
    localparam int          LINE_TOP         = 7;

    // ------------------------------------------------------------
    // timing: strap settle after reset release, in clock cycles
    // ------------------------------------------------------------
    localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

    typedef enum logic [1:0] {
        STRAP_WAIT = 2'b01,
        STRAP_DONE = 2'b10
    } strap_state_e;

endpackage

// file: port3_gpio.sv
// eight-line port with external-bus control functions, APB slave
// How it works
// - eight lines, each in or out, except lines 0 and 1 only drive
// - direction register picks in (0) or out (1) for lines 2 to 7 only
// - reset sets latch bits 0, 1 and 7 to one
// - reset loads latch bits 2 to 6 from the pull-up strap
// - reset clears implemented direction and function bits
// - after reset lines 0,1 drive high; 2-6 inputs, pull-up per strap
// - after reset line 7 is an input with pull-up on
// - line 0 function drives read strobe only during external access
// - line 1 function drives write strobe only during external access
// - lines 2 and 6 in function mode pull up while bus granted away
// - function bit one selects the bus signal, zero the port
`timescale 1ns/1ns
module port3_gpio (
    input  wire logic                          sys_clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [port3_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic                          pullup_strap_pin_i,
    input  wire logic [7:0]                    pin_i,
    output logic      [7:0]                    pin_o,
    output logic      [7:0]                    pin_oe_o,
    output logic      [7:0]                    pullup_en_o,
    input  wire logic                          ext_access_i,
    input  wire logic                          rd_strobe_n_i,
    input  wire logic                          wr_strobe_n_i,
    input  wire logic                          high_byte_write_strobe_n_i,
    input  wire logic                          bus_acknowledge_n_i,
    input  wire logic                          rw_dir_i,
    output logic                               bus_request_in_n_o
);
    import port3_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic       rst_meta_n;
    logic       rst_n;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // pin and strap synchronisers
    // ------------------------------------------------------------
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_level;
    logic       strap_s1;
    logic       strap_s2;
    logic       strap_s3;
    wire  [7:0] pin_agree = ~(pin_s2 ^ pin_s3);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1    <= 8'h00;
            pin_s2    <= 8'h00;
            pin_s3    <= 8'h00;
            pin_level <= 8'h00;
            strap_s1  <= 1'b0;
            strap_s2  <= 1'b0;
            strap_s3  <= 1'b0;
        end else begin
            pin_s1    <= pin_i;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_level <= (pin_agree & pin_s3) | (~pin_agree & pin_level);
            strap_s1  <= pullup_strap_pin_i;
            strap_s2  <= strap_s1;
            strap_s3  <= strap_s2;
        end
    end

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    // the latch cannot take the strap under the async reset, so the
    // strap bits are loaded once the synchroniser has filled and agrees
    strap_state_e strap_state;
    strap_state_e next_strap_state;
    logic [1:0]   settle_cnt;
    wire          settled     = (settle_cnt == STRAP_SETTLE);
    wire          strap_agree = (strap_s2 == strap_s3);
    wire          strap_load  = (strap_state == STRAP_WAIT) && settled
                                && strap_agree;

    always_comb begin
        next_strap_state = strap_state;
        case (strap_state)
            STRAP_WAIT: begin
                if (strap_load) begin
                    next_strap_state = STRAP_DONE;
                end
            end
            STRAP_DONE: begin
                next_strap_state = STRAP_DONE;
            end
            default: begin
                next_strap_state = STRAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_state <= STRAP_WAIT;
            settle_cnt  <= 2'h0;
        end else begin
            strap_state <= next_strap_state;
            if (!settled) begin
                settle_cnt <= settle_cnt + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        hit_data  = (paddr_i == ADDR_DATA);
    wire        hit_dir   = (paddr_i == ADDR_DIRECTION);
    wire        hit_func  = (paddr_i == ADDR_FUNCTION);
    wire        mapped    = hit_data | hit_dir | hit_func;
    wire        setup     = psel_i & ~penable_i;
    wire        access    = psel_i & penable_i;
    wire        wr_en     = access & pwrite_i & mapped;
    wire        wr_data   = wr_en & hit_data;
    wire        wr_dir    = wr_en & hit_dir;
    wire        wr_func   = wr_en & hit_func;

    // ------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------
    logic [7:0] port_three_data;
    logic [7:0] port_three_direction;
    logic [7:0] port_three_function_select;
    wire  [7:0] strap_bits = {8{strap_s3}} & STRAP_MASK;
    wire  [7:0] latch_strapped = (port_three_data & ~STRAP_MASK)
                                 | strap_bits;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            port_three_data <= LATCH_RESET;
        end else if (wr_data) begin
            port_three_data <= pwdata_i[7:0];
        end else if (strap_load) begin
            port_three_data <= latch_strapped;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            port_three_direction       <= DIR_RESET;
            port_three_function_select <= FUNC_RESET;
        end else begin
            if (wr_dir) begin
                port_three_direction <= pwdata_i[7:0] & DIR_IMPL_MASK;
            end
            if (wr_func) begin
                port_three_function_select <= pwdata_i[7:0]
                                              & FUNC_IMPL_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // line steering
    // ------------------------------------------------------------
    wire  [7:0] fsel      = port_three_function_select;
    wire  [7:0] is_out    = port_three_direction | OUT_ONLY_MASK;
    wire        granted   = ~bus_acknowledge_n_i;
    wire        line0_bus = ext_access_i ? rd_strobe_n_i : 1'b1;
    wire        line1_bus = ext_access_i ? wr_strobe_n_i : 1'b1;
    wire        line2_bus = ext_access_i ? high_byte_write_strobe_n_i
                                         : 1'b1;
    wire  [7:0] bus_value = {1'b1, rw_dir_i, bus_acknowledge_n_i, 1'b1,
                             1'b1, line2_bus, line1_bus, line0_bus};
    // lines 2 and 6 let go of the bus while another master owns it
    wire  [7:0] bus_oe    = {1'b0, ~granted, 1'b1, 1'b0,
                             1'b0, ~granted, 1'b1, 1'b1};
    wire  [7:0] bus_pull  = {1'b0, granted, 1'b0, 1'b0,
                             1'b0, granted, 1'b0, 1'b0};
    wire  [7:0] next_pin_o  = (fsel & bus_value)
                              | (~fsel & port_three_data);
    wire  [7:0] next_pin_oe = (fsel & bus_oe) | (~fsel & is_out);
    // an undriven input line pulls up when its latch bit holds one
    wire  [7:0] port_pull   = ~is_out & port_three_data;
    wire  [7:0] next_pull   = (fsel & (bus_pull | (~bus_oe & port_pull)))
                              | (~fsel & port_pull);
    wire  [7:0] read_data   = (is_out & port_three_data)
                              | (~is_out & pin_level);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_o       <= LATCH_RESET;
            pin_oe_o    <= OUT_ONLY_MASK;
            pullup_en_o <= LATCH_RESET & ~OUT_ONLY_MASK;
        end else begin
            pin_o       <= next_pin_o;
            pin_oe_o    <= next_pin_oe;
            pullup_en_o <= next_pull;
        end
    end

    // bus request comes in on line 4 once filtered
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_request_in_n_o <= 1'b1;
        end else begin
            bus_request_in_n_o <= fsel[LINE_BUS_REQUEST_IN] ? pin_level[LINE_BUS_REQUEST_IN]
                                                   : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // read data is taken in the setup cycle so prdata comes from a
    // flop; the control registers are write-only and read as zero
    wire  [31:0] next_prdata = {24'h0, hit_data ? read_data : 8'h00};

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0;
        end else if (setup) begin
            prdata_o <= next_prdata;
        end
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_outonly_drive: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (pin_oe_o[1:0] == 2'b11))
        else $error("line 0 or 1 not driving");

    a_dir_write_oe: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        wr_dir && !fsel[3] && !wr_func ##1 !wr_func [*1] |=>
        pin_oe_o[3] == $past(port_three_direction[3]))
        else $error("direction bit did not steer line 3 enable");

    a_latch_reset: assert property (
        @(posedge sys_clk_i)
        $rose(rst_n) |-> (port_three_data[1:0] == 2'b11)
        && port_three_data[LINE_TOP])
        else $error("latch bits 0,1,7 not set after reset");

    a_strap_load: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        strap_load && !wr_data |=>
        port_three_data[6:2] == {5{$past(strap_s3)}})
        else $error("strap not loaded into latch bits 2 to 6");

    a_unimpl_zero: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (port_three_direction[1:0] == 2'b00) && !fsel[3] && !fsel[7])
        else $error("unimplemented control bit set");

    a_reset_inputs: assert property (
        @(posedge sys_clk_i)
        $rose(rst_n) |-> (pin_oe_o[7:2] == 6'h00)
        && pin_o[1] && pin_o[0])
        else $error("lines wrong right after reset");

    a_top_pullup: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        $rose(rst_n) ##1 1'b1 |-> pullup_en_o[LINE_TOP])
        else $error("line 7 pull-up off after reset");

    a_rd_strobe: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        fsel[LINE_RD] && !ext_access_i && !wr_func |=>
        pin_o[LINE_RD])
        else $error("read strobe outside external access");

    a_wr_strobe: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        fsel[LINE_WR] && ext_access_i && !wr_func |=>
        pin_o[LINE_WR] == $past(wr_strobe_n_i))
        else $error("write strobe not passed during access");

    a_grant_pullup: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        fsel[LINE_RW] && !bus_acknowledge_n_i && !wr_func |=>
        pullup_en_o[LINE_RW] && !pin_oe_o[LINE_RW])
        else $error("line 6 not released with pull-up");

    a_bus_request_in_input: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        fsel[LINE_BUS_REQUEST_IN] && !wr_func |=> !pin_oe_o[LINE_BUS_REQUEST_IN])
        else $error("bus request line driven");

    a_read_value: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        setup && hit_data && !pwrite_i |=>
        prdata_o[1:0] == $past(port_three_data[1:0]))
        else $error("read of output-only lines wrong");

endmodule

// file: port3_pins_model.sv
// model of the pins and external-bus devices around the eight-line port
`timescale 1ns/1ns
module port3_pins_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] drive_oe_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_oe_i,
    output logic      [7:0] level_o
);
    logic [7:0] wander = 8'h55;

    // a floating line toggles every cycle, so a missing pull-up shows up
    always_ff @(posedge clk_i) begin
        wander <= ~wander;
    end

    // the port's own drive wins, then an external driver, then the pull-up
    assign level_o = (drive_oe_i & drive_i)
                   | (~drive_oe_i & ext_oe_i & ext_val_i)
                   | (~drive_oe_i & ~ext_oe_i & (pullup_i | wander));
endmodule

// file: port3_gpio_test.sv
// self-checking bench for the eight-line port with bus functions
`timescale 1ns/1ns
module port3_gpio_test;
    import port3_pkg::*;
    logic        sys_clk_i, nrst_i, psel_i, penable_i, pwrite_i, strap, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, ea, rd_n, wr_n, hwr_n, bus_acknowledge_out_n, rw;
    logic [7:0]  pin_lvl, pin_o, pin_oe_o, pullup_en_o, ext_val, ext_oe, d, v;
    logic        bus_request_in_n;
    logic [6:0]  r;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    port3_gpio uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pullup_strap_pin_i(strap), .pin_i(pin_lvl),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
        .ext_access_i(ea), .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n),
        .high_byte_write_strobe_n_i(hwr_n), .bus_acknowledge_n_i(bus_acknowledge_out_n),
        .rw_dir_i(rw), .bus_request_in_n_o(bus_request_in_n));

    port3_pins_model pins (.clk_i(sys_clk_i), .drive_i(pin_o),
        .drive_oe_i(pin_oe_o), .pullup_i(pullup_en_o), .ext_val_i(ext_val),
        .ext_oe_i(ext_oe), .level_o(pin_lvl));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_oe(input logic [7:0] dir);
        return (dir & DIR_IMPL_MASK) | OUT_ONLY_MASK;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] dir, lat, lvl);
        return (lat & exp_oe(dir)) | (lvl & ~exp_oe(dir));
    endfunction

    task automatic check(input logic [31:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // one transfer, then a spare edge so psel is never set twice at once
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic do_reset(input logic s);
        nrst_i <= 1'b0;
        strap <= s;
        repeat (5) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst_i, psel_i, penable_i, pwrite_i, strap} = 5'h01;
        {paddr_i, pwdata_i, ext_val, ext_oe} = '0;
        {ea, rd_n, wr_n, hwr_n, bus_acknowledge_out_n, rw} = 6'h1e;
        d = 8'($urandom(32'h0de9));
        do_reset(1'b1);
        check(pin_oe_o, 8'h03, "oe after reset");
        check(pin_o[1:0], 2'b11, "lines 0,1");
        check(pullup_en_o, 8'hfc, "pull-ups strap high");
        apb(1'b0, ADDR_DATA, 32'h0);
        check(rd, 32'hff, "data strap high");
        check(err, 1'b0, "mapped access error");
        apb(1'b0, ADDR_FUNCTION, 32'h0);
        check(rd, 32'h0, "function read");
        check(bus_request_in_n, 1'b1, "request idle");
        do_reset(1'b0);
        check(pullup_en_o, 8'h80, "pull-ups strap low");
        apb(1'b1, ADDR_DIRECTION, 32'hff);
        repeat (2) @(posedge sys_clk_i);
        check(pin_o, 8'h83, "latch strap low");
        check(pin_oe_o, 8'hff, "all out");
        // random direction, latch and external levels, corners first
        for (int i = 0; i < 20; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            v = (i == 0) ? 8'h00 : 8'($urandom);
            apb(1'b1, ADDR_DIRECTION, {24'h0, d});
            apb(1'b1, ADDR_DATA, {24'h0, v});
            ext_oe <= ~exp_oe(d);
            ext_val <= 8'($urandom);
            repeat (6) @(posedge sys_clk_i);
            check(pin_oe_o, exp_oe(d), "direction");
            check(pin_o & exp_oe(d), v & exp_oe(d), "drive");
            check(pullup_en_o, v & ~exp_oe(d), "input pull-up");
            apb(1'b0, ADDR_DATA, 32'h0);
            check(rd, {24'h0, exp_rd(d, v, ext_val)}, "read");
        end
        // bus role on every function line, unimplemented bits set too
        apb(1'b1, ADDR_FUNCTION, 32'hff);
        apb(1'b1, ADDR_DIRECTION, 32'h0);
        ext_oe <= 8'h10;
        for (int i = 0; i < 16; i++) begin
            r = (i == 0) ? 7'h00 : 7'($urandom);
            {rw, bus_acknowledge_out_n, hwr_n, wr_n, rd_n, ea} <= r[5:0];
            ext_val <= {3'h0, r[6], 4'h0};
            repeat (6) @(posedge sys_clk_i);
            check(pin_o[0], r[0] ? r[1] : 1'b1, "read strobe");
            check(pin_o[1], r[0] ? r[2] : 1'b1, "write strobe");
            check({pin_oe_o[5], pin_o[5]}, {1'b1, r[4]}, "grant");
            check(bus_request_in_n, r[6], "request in");
            check(pin_oe_o & 8'h88, 8'h00, "unused function");
            if (r[4])
                check({pin_oe_o[6], pin_o[6], pin_oe_o[2], pin_o[2]},
                      {1'b1, r[5], 1'b1, r[0] ? r[3] : 1'b1},
                      "direction and high byte");
            else
                check({pin_oe_o[6], pin_oe_o[2], pullup_en_o[6],
                       pullup_en_o[2]}, 4'b0011, "granted away");
        end
        apb(1'b1, ADDR_FUNCTION, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        check(bus_request_in_n, 1'b1, "request port mode");
        check(pin_o[1:0], v[1:0], "port mode lines 0,1");
        apb(1'b1, 12'h070, 32'hff);
        check(err, 1'b1, "unmapped write");
        apb(1'b0, 12'h070, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check(err, 1'b1, "unmapped read error");
        summarize();
    end
endmodule
